// ### common/tcr_pkg.sv
package tcr_pkg;
    localparam logic [7:0] XMIT_CONF_OFF = 8'h70;
    localparam logic [7:0] HW_CONF_OFF = 8'h74;
    localparam logic [7:0] RST_CTL_OFF = 8'h78;
    localparam int TXS_FLUSH_BIT = 15;
    localparam int TXD_FLUSH_BIT = 14;
    localparam int OVR_PERMIT_BIT = 2;
    localparam int TX_ON_BIT = 1;
    localparam int STOP_BIT = 0;
    localparam int PORT_END_BIT = 29;
    localparam int SEL_END_BIT = 28;
    localparam int STRAP_BIT = 24;
    localparam int REQ_ONE_BIT = 20;
    localparam int FSZ_LSB = 16;
    localparam int RST_TMO_BIT = 1;
    localparam int SWRST_GO_BIT = 0;
    localparam logic [3:0] FSZ_RST = 4'h5;
    localparam logic [3:0] FSZ_MIN = 4'h2;
    localparam logic [3:0] FSZ_MAX = 4'hE;
    localparam logic [15:0] KB_BYTES = 16'h0400;
    localparam logic [15:0] TXS_BYTES = 16'h0200;
    localparam logic [15:0] TOTAL_BYTES = 16'h4000;
    localparam int RXS_SHIFT = 4;
    localparam int SOFTWARE_RESET_WAIT_NS = 10000;
    localparam int CLK_NS = 100;
    localparam int SOFTWARE_RESET_WAIT_CYC = SOFTWARE_RESET_WAIT_NS / CLK_NS;
endpackage

// ### common/tcr_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tcr_ctl_if;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
    modport master (output wr, output rd, output addr, output wdata);
    modport slave (input wr, input rd, input addr, input wdata);
endinterface
`default_nettype wire

// ### core/tcr_fifo_map.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_fifo_map (
    input wire logic [3:0] size_kb,
    output logic [15:0] tx_data_bytes,
    output logic [15:0] tx_status_bytes,
    output logic [15:0] rx_data_bytes,
    output logic [15:0] rx_status_bytes
);
    logic [15:0] tx_total;
    logic [15:0] rx_total;
    // Product fits in 16 bits since the field is at most 15.
    assign tx_total = 16'({12'h000, size_kb} * tcr_pkg::KB_BYTES);
    assign tx_status_bytes = tcr_pkg::TXS_BYTES;
    assign tx_data_bytes = tx_total - tcr_pkg::TXS_BYTES;
    assign rx_total = tcr_pkg::TOTAL_BYTES - tx_total;
    assign rx_status_bytes = rx_total >> tcr_pkg::RXS_SHIFT;
    assign rx_data_bytes = rx_total - rx_status_bytes;
endmodule
`default_nettype wire

// ### core/tcr_ahb_slave.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_ahb_slave (
    input wire logic clk,
    input wire logic software_reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    tcr_ctl_if.master ctl
);
    logic wr_pend_r;
    logic rd_pend_r;
    logic [7:0] addr_r;
    logic take;
    assign take = hsel && hready && htrans[1];
    always_ff @(posedge clk) begin
        if (software_reset) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            wr_pend_r <= take && hwrite;
            rd_pend_r <= take && !hwrite;
            if (take) begin
                addr_r <= haddr[7:0];
            end
        end
    end
    // Writes act in the data phase; reads are sampled at the address phase so data is ready.
    assign ctl.wr = wr_pend_r;
    assign ctl.rd = take && !hwrite;
    assign ctl.addr = wr_pend_r ? addr_r : haddr[7:0];
    assign ctl.wdata = hwdata;
endmodule
`default_nettype wire

// ### core/tcr_regs.sv
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tcr_regs #(
    parameter int SOFTWARE_RESET_WAIT = tcr_pkg::SOFTWARE_RESET_WAIT_CYC
) (
    input wire logic CLK,
    input wire logic SOFTWARE_RESET,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic STRAP_AUTO_XOVER,
    input wire logic LINK_CLKS_OK,
    input wire logic TX_FRAME_BUSY,
    input wire logic TX_STATUS_FULL,
    input wire logic TX_FRAME_QUEUED,
    output logic TX_SEND_OK,
    output logic TX_STATUS_FULL_IRQ,
    output logic TX_STATUS_PTR_CLR,
    output logic TX_DATA_PTR_CLR,
    output logic PORT_BIG_ENDIAN,
    output logic SEL_BIG_ENDIAN,
    output logic MUST_BE_ONE,
    output logic [15:0] TX_DATA_BYTES,
    output logic [15:0] TX_STATUS_BYTES,
    output logic [15:0] RX_DATA_BYTES,
    output logic [15:0] RX_STATUS_BYTES,
    output logic SOFT_RESET_PULSE,
    output logic ERR_CLR
);
    typedef enum logic [1:0] {TCR_IDLE, TCR_RUN, TCR_DRAIN} tcr_tx_t;
    typedef enum logic [1:0] {TCR_SR_IDLE, TCR_SR_WAIT, TCR_SR_DONE} tcr_sr_t;

    tcr_ctl_if ctl ();

    tcr_ahb_slave u_bus (
        .clk(CLK),
        .software_reset(SOFTWARE_RESET),
        .hsel(HSEL),
        .haddr(HADDR),
        .htrans(HTRANS),
        .hwrite(HWRITE),
        .hready(HREADY),
        .hwdata(HWDATA),
        .ctl(ctl)
    );

    logic tx_on_r;
    logic stop_r;
    logic ovr_permit_r;
    logic txs_flush_r;
    logic txd_flush_r;
    logic port_end_r;
    logic sel_end_r;
    logic strap_r;
    logic strap_taken_r;
    logic req_one_r;
    logic [3:0] fsz_r;
    logic rst_tmo_r;
    logic soft_rst_r;
    logic [15:0] sr_cnt_r;
    tcr_tx_t tx_st_r;
    tcr_sr_t sr_st_r;
    logic wr_tx;
    logic wr_hw;
    logic wr_rst;
    logic halted;
    logic [3:0] fsz_in;
    logic [31:0] rd_nxt;
    logic [31:0] xmit_conf_val;
    logic [31:0] hw_conf_val;
    logic [31:0] rst_val;

    assign wr_tx = ctl.wr && (ctl.addr == tcr_pkg::XMIT_CONF_OFF);
    assign wr_hw = ctl.wr && (ctl.addr == tcr_pkg::HW_CONF_OFF);
    assign wr_rst = ctl.wr && (ctl.addr == tcr_pkg::RST_CTL_OFF);
    assign fsz_in = ctl.wdata[tcr_pkg::FSZ_LSB +: 4];

    // The transmitter counts as halted once a stop request sees no frame in flight.
    // A stop requested while already idle must also clear, or the bit would lock up.
    assign halted = stop_r && (tx_st_r != TCR_RUN) && !TX_FRAME_BUSY;

    // Transmit sequencer: a frame that has started always runs to its end.
    always_ff @(posedge CLK) begin
        if (SOFTWARE_RESET || soft_rst_r) begin
            tx_st_r <= TCR_IDLE;
        end else begin
            unique case (tx_st_r)
                TCR_IDLE: begin
                    if (tx_on_r && !stop_r) begin
                        tx_st_r <= TCR_RUN;
                    end
                end
                TCR_RUN: begin
                    if (stop_r) begin
                        tx_st_r <= TCR_DRAIN;
                    end else if (!tx_on_r) begin
                        tx_st_r <= TCR_IDLE;
                    end
                end
                TCR_DRAIN: begin
                    if (halted) begin
                        tx_st_r <= TCR_IDLE;
                    end
                end
            endcase
        end
    end

    // New frames start only in the run state, and then only if status space is free or overrun is permitted.
    assign TX_SEND_OK = (tx_st_r == TCR_RUN) && TX_FRAME_QUEUED
        && (ovr_permit_r || !TX_STATUS_FULL);
    assign TX_STATUS_FULL_IRQ = TX_STATUS_FULL;

    always_ff @(posedge CLK) begin
        if (SOFTWARE_RESET || soft_rst_r) begin
            tx_on_r <= 1'b0;
            stop_r <= 1'b0;
            ovr_permit_r <= 1'b0;
        end else begin
            if (halted) begin
                tx_on_r <= 1'b0;
            end else if (wr_tx) begin
                tx_on_r <= ctl.wdata[tcr_pkg::TX_ON_BIT];
            end
            if (halted) begin
                stop_r <= 1'b0;
            end else if (wr_tx && !stop_r) begin
                stop_r <= ctl.wdata[tcr_pkg::STOP_BIT];
            end
            if (wr_tx) begin
                ovr_permit_r <= ctl.wdata[tcr_pkg::OVR_PERMIT_BIT];
            end
        end
    end

    // Flush strobes are one-cycle pulses; they read back as zero afterwards.
    always_ff @(posedge CLK) begin
        if (SOFTWARE_RESET || soft_rst_r) begin
            txs_flush_r <= 1'b0;
            txd_flush_r <= 1'b0;
        end else begin
            txs_flush_r <= wr_tx && ctl.wdata[tcr_pkg::TXS_FLUSH_BIT];
            txd_flush_r <= wr_tx && ctl.wdata[tcr_pkg::TXD_FLUSH_BIT];
        end
    end
    assign TX_STATUS_PTR_CLR = txs_flush_r;
    assign TX_DATA_PTR_CLR = txd_flush_r;

    // Endianness bits are cleared by the pin reset only.
    always_ff @(posedge CLK) begin
        if (SOFTWARE_RESET) begin
            port_end_r <= 1'b0;
            sel_end_r <= 1'b0;
        end else if (wr_hw) begin
            port_end_r <= ctl.wdata[tcr_pkg::PORT_END_BIT];
            sel_end_r <= ctl.wdata[tcr_pkg::SEL_END_BIT];
        end
    end
    assign PORT_BIG_ENDIAN = port_end_r;
    assign SEL_BIG_ENDIAN = sel_end_r;

    // The strap is captured in the first cycle after reset release, then held.
    always_ff @(posedge CLK) begin
        if (SOFTWARE_RESET) begin
            strap_r <= 1'b0;
            strap_taken_r <= 1'b0;
        end else if (!strap_taken_r) begin
            strap_r <= STRAP_AUTO_XOVER;
            strap_taken_r <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SOFTWARE_RESET || soft_rst_r) begin
            req_one_r <= 1'b0;
            fsz_r <= tcr_pkg::FSZ_RST;
        end else if (wr_hw) begin
            req_one_r <= ctl.wdata[tcr_pkg::REQ_ONE_BIT];
            // Reserved sizes would corrupt the memory split, so they are ignored.
            if (fsz_in >= tcr_pkg::FSZ_MIN && fsz_in <= tcr_pkg::FSZ_MAX) begin
                fsz_r <= fsz_in;
            end
        end
    end
    assign MUST_BE_ONE = req_one_r;

    tcr_fifo_map u_map (
        .size_kb(fsz_r),
        .tx_data_bytes(TX_DATA_BYTES),
        .tx_status_bytes(TX_STATUS_BYTES),
        .rx_data_bytes(RX_DATA_BYTES),
        .rx_status_bytes(RX_STATUS_BYTES)
    );

    // Soft reset waits for the link clocks; giving up sets the timeout flag.
    always_ff @(posedge CLK) begin
        if (SOFTWARE_RESET) begin
            sr_st_r <= TCR_SR_IDLE;
            sr_cnt_r <= 16'h0000;
            soft_rst_r <= 1'b0;
            rst_tmo_r <= 1'b0;
        end else begin
            soft_rst_r <= 1'b0;
            unique case (sr_st_r)
                TCR_SR_IDLE: begin
                    if (wr_rst && ctl.wdata[tcr_pkg::SWRST_GO_BIT]) begin
                        sr_st_r <= TCR_SR_WAIT;
                        sr_cnt_r <= 16'h0000;
                        rst_tmo_r <= 1'b0;
                    end
                end
                TCR_SR_WAIT: begin
                    if (LINK_CLKS_OK) begin
                        sr_st_r <= TCR_SR_DONE;
                        soft_rst_r <= 1'b1;
                    end else if (sr_cnt_r == 16'(SOFTWARE_RESET_WAIT - 1)) begin
                        sr_st_r <= TCR_SR_IDLE;
                        rst_tmo_r <= 1'b1;
                    end else begin
                        sr_cnt_r <= sr_cnt_r + 16'h0001;
                    end
                end
                TCR_SR_DONE: begin
                    sr_st_r <= TCR_SR_IDLE;
                end
                default: begin
                    sr_st_r <= TCR_SR_IDLE;
                end
            endcase
        end
    end
    assign SOFT_RESET_PULSE = soft_rst_r;
    assign ERR_CLR = soft_rst_r;

    always_comb begin
        xmit_conf_val = 32'h0000_0000;
        xmit_conf_val[tcr_pkg::OVR_PERMIT_BIT] = ovr_permit_r;
        xmit_conf_val[tcr_pkg::TX_ON_BIT] = tx_on_r;
        xmit_conf_val[tcr_pkg::STOP_BIT] = stop_r;
        hw_conf_val = 32'h0000_0000;
        hw_conf_val[tcr_pkg::PORT_END_BIT] = port_end_r;
        hw_conf_val[tcr_pkg::SEL_END_BIT] = sel_end_r;
        hw_conf_val[tcr_pkg::STRAP_BIT] = strap_r;
        hw_conf_val[tcr_pkg::REQ_ONE_BIT] = req_one_r;
        hw_conf_val[tcr_pkg::FSZ_LSB +: 4] = fsz_r;
        hw_conf_val[tcr_pkg::RST_TMO_BIT] = rst_tmo_r;
        rst_val = 32'h0000_0000;
        rst_val[tcr_pkg::SWRST_GO_BIT] = (sr_st_r != TCR_SR_IDLE);
        unique case (ctl.addr)
            tcr_pkg::XMIT_CONF_OFF: rd_nxt = xmit_conf_val;
            tcr_pkg::HW_CONF_OFF: rd_nxt = hw_conf_val;
            tcr_pkg::RST_CTL_OFF: rd_nxt = rst_val;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SOFTWARE_RESET) begin
            HRDATA <= 32'h0000_0000;
        end else if (ctl.rd) begin
            HRDATA <= rd_nxt;
        end
    end

    // A read right behind a write would share the one register address path, so the
    // write's data phase is stretched by one cycle and the read then sees the new value.
    assign HREADYOUT = !(ctl.wr && HSEL && HTRANS[1] && !HWRITE);
    assign HRESP = 1'b0;
endmodule
`default_nettype wire

// ### test/tcr_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the frame engine: starts a frame whenever the block allows it and no frame is running.
// Frames last long enough that a stop request always lands in mid-frame.
module tcr_tx_model #(
    parameter int FRAME_LEN = 30
) (
    input wire logic clk,
    input wire logic software_reset,
    input wire logic send_ok,
    output logic busy
);
    int cnt_r;
    always_ff @(posedge clk) begin
        if (software_reset) begin
            cnt_r <= 0;
        end else if (cnt_r != 0) begin
            cnt_r <= cnt_r - 1;
        end else if (send_ok) begin
            cnt_r <= FRAME_LEN;
        end
    end
    assign busy = (cnt_r != 0);
endmodule
`default_nettype wire

// ### test/tcr_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_regs_sva (
    input wire logic CLK,
    input wire logic SOFTWARE_RESET,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    input wire logic TX_STATUS_FULL,
    input wire logic TX_FRAME_QUEUED,
    input wire logic TX_SEND_OK,
    input wire logic TX_STATUS_FULL_IRQ,
    input wire logic TX_STATUS_PTR_CLR,
    input wire logic TX_DATA_PTR_CLR,
    input wire logic [15:0] TX_DATA_BYTES,
    input wire logic [15:0] TX_STATUS_BYTES,
    input wire logic [15:0] RX_DATA_BYTES,
    input wire logic [15:0] RX_STATUS_BYTES,
    input wire logic SOFT_RESET_PULSE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SOFTWARE_RESET);
    logic wr_tx_r;
    logic permit_r;
    logic [31:0] tx_all;
    assign tx_all = 32'(TX_DATA_BYTES) + 32'(TX_STATUS_BYTES);
    // Shadow of the overrun permit, rebuilt from bus writes to the transmit register.
    always_ff @(posedge CLK) begin
        if (SOFTWARE_RESET || SOFT_RESET_PULSE) begin
            wr_tx_r <= 1'b0;
            permit_r <= 1'b0;
        end else begin
            wr_tx_r <= HSEL && HREADY && HTRANS[1] && HWRITE && (HADDR[7:0] == 8'h70);
            if (wr_tx_r) begin
                permit_r <= HWDATA[2];
            end
        end
    end
    sequence s_wr_tx;
        HSEL && HREADY && HTRANS[1] && HWRITE && (HADDR[7:0] == 8'h70) ##1 1'b1;
    endsequence
    property p_flush_status;
        s_wr_tx ##0 HWDATA[15] |=> TX_STATUS_PTR_CLR ##1 !TX_STATUS_PTR_CLR;
    endproperty
    a_flush_status: assert property (p_flush_status)
        else $error("status flush pulse missing");
    property p_flush_data;
        s_wr_tx ##0 HWDATA[14] |=> TX_DATA_PTR_CLR ##1 !TX_DATA_PTR_CLR;
    endproperty
    a_flush_data: assert property (p_flush_data)
        else $error("data flush pulse missing");
    property p_suspend;
        TX_STATUS_FULL && !permit_r |-> !TX_SEND_OK;
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("send allowed with full status and no permit");
    property p_irq;
        TX_STATUS_FULL_IRQ == TX_STATUS_FULL;
    endproperty
    a_irq: assert property (p_irq)
        else $error("status full interrupt does not follow full");
    property p_send_queued;
        TX_SEND_OK |-> TX_FRAME_QUEUED;
    endproperty
    a_send_queued: assert property (p_send_queued)
        else $error("send allowed with nothing queued");
    property p_tx_size;
        tx_all >= 32'h0000_0800 && tx_all <= 32'h0000_3800 && tx_all[9:0] == 10'h000;
    endproperty
    a_tx_size: assert property (p_tx_size)
        else $error("transmit allocation out of range");
    property p_txs;
        TX_STATUS_BYTES == 16'h0200;
    endproperty
    a_txs: assert property (p_txs)
        else $error("transmit status size wrong");
    property p_total;
        tx_all + 32'(RX_DATA_BYTES) + 32'(RX_STATUS_BYTES) == 32'h0000_4000;
    endproperty
    a_total: assert property (p_total)
        else $error("allocations do not fill the memory");
    property p_rxs;
        {RX_STATUS_BYTES, 4'h0} == {4'h0, RX_DATA_BYTES} + {4'h0, RX_STATUS_BYTES};
    endproperty
    a_rxs: assert property (p_rxs)
        else $error("receive status share wrong");
endmodule
bind tcr_regs tcr_regs_sva i_tcr_regs_sva (.CLK, .SOFTWARE_RESET, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HREADY, .HWDATA, .TX_STATUS_FULL, .TX_FRAME_QUEUED, .TX_SEND_OK, .TX_STATUS_FULL_IRQ,
    .TX_STATUS_PTR_CLR, .TX_DATA_PTR_CLR, .TX_DATA_BYTES, .TX_STATUS_BYTES, .RX_DATA_BYTES,
    .RX_STATUS_BYTES, .SOFT_RESET_PULSE);
`default_nettype wire

// ### test/tcr_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_regs_test;
    logic clk = 0, software_reset = 1, hsel = 0, hwrite = 0, strap = 1, link_ok = 1, full = 0;
    logic queued = 1, hrdy, hresp, busy, send_ok, irq, clr_s, clr_d, pbe, sbe, must1;
    logic srp, errclr;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, q;
    logic [15:0] txd, txs, rxd, rxs;
    int errors = 0, total_checks = 0;
    always #50 clk = ~clk;
    tcr_regs #(.SOFTWARE_RESET_WAIT(5)) i_tcr_regs (.CLK(clk), .SOFTWARE_RESET(software_reset), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HREADY(hrdy), .HWDATA(hwdata),
        .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .STRAP_AUTO_XOVER(strap),
        .LINK_CLKS_OK(link_ok), .TX_FRAME_BUSY(busy), .TX_STATUS_FULL(full),
        .TX_FRAME_QUEUED(queued), .TX_SEND_OK(send_ok), .TX_STATUS_FULL_IRQ(irq),
        .TX_STATUS_PTR_CLR(clr_s), .TX_DATA_PTR_CLR(clr_d), .PORT_BIG_ENDIAN(pbe),
        .SEL_BIG_ENDIAN(sbe), .MUST_BE_ONE(must1), .TX_DATA_BYTES(txd), .TX_STATUS_BYTES(txs),
        .RX_DATA_BYTES(rxd), .RX_STATUS_BYTES(rxs), .SOFT_RESET_PULSE(srp), .ERR_CLR(errclr));
    tcr_tx_model i_tcr_tx_model (.clk(clk), .software_reset(software_reset), .send_ok(send_ok), .busy(busy));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Address phase held until ready, then data phase held until ready; data taken there.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check($sformatf("reg %h", a), q, exp);
        check("hresp", {31'h0, hresp}, 32'h0000_0000);
    endtask
    task automatic t_reset_values;
        rdc(8'h74, 32'h0105_0000);
        rdc(8'h70, 32'h0000_0000);
        check("must1", {31'h0, must1}, 32'h0000_0000);
        check("txd", {txd, rxd}, 32'h1200_2940);
        check("rxs", {16'h0, rxs}, 32'h0000_02C0);
    endtask
    task automatic t_hw_config;
        bus(1'b1, 8'h74, 32'hF1FE_FFFF);
        rdc(8'h74, 32'h311E_0000);
        check("endian", {30'h0, pbe, sbe}, 32'h0000_0003);
        check("sizes", {txd, rxd}, 32'h3600_0780);
        check("rxs", {16'h0, rxs}, 32'h0000_0080);
        bus(1'b1, 8'h74, 32'h3011_0000);
        rdc(8'h74, 32'h311E_0000);
    endtask
    task automatic t_transmit;
        full <= 1'b1;
        bus(1'b1, 8'h70, 32'h0000_0002);
        rdc(8'h70, 32'h0000_0002);
        check("irq", {30'h0, send_ok, irq}, 32'h0000_0001);
        bus(1'b1, 8'h70, 32'h0000_0006);
        @(negedge clk);
        check("permit", {30'h0, send_ok, irq}, 32'h0000_0003);
        @(posedge clk);
        full <= 1'b0;
        for (int i = 0; i < 20 && busy !== 1'b1; i++) @(negedge clk);
        bus(1'b1, 8'h70, 32'h0000_0007);
        rdc(8'h70, 32'h0000_0007);
        bus(1'b1, 8'h70, 32'h0000_0006);
        rdc(8'h70, 32'h0000_0007);
        for (int i = 0; i < 60 && busy !== 1'b0; i++) @(negedge clk);
        repeat (2) @(negedge clk);
        check("halted", {31'h0, busy | send_ok}, 32'h0000_0000);
        rdc(8'h70, 32'h0000_0004);
        bus(1'b1, 8'h70, 32'h0000_C004);
        rdc(8'h70, 32'h0000_0004);
    endtask
    task automatic t_soft_reset;
        link_ok <= 1'b0;
        bus(1'b1, 8'h78, 32'h0000_0001);
        repeat (12) @(posedge clk);
        rdc(8'h74, 32'h311E_0002);
        link_ok <= 1'b1;
        bus(1'b1, 8'h78, 32'h0000_0001);
        for (int i = 0; i < 40 && srp !== 1'b1; i++) @(negedge clk);
        check("errclr", {30'h0, srp, errclr}, 32'h0000_0003);
        repeat (2) @(posedge clk);
        rdc(8'h74, 32'h3105_0000);
        check("endian kept", {30'h0, pbe, sbe}, 32'h0000_0003);
        rdc(8'h70, 32'h0000_0000);
        rdc(8'h7C, 32'h0000_0000);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        software_reset <= 1'b0;
        t_reset_values();
        // The host sets the must-be-one bit with the transmitter idle.
        bus(1'b1, 8'h74, 32'h0015_0000);
        t_hw_config();
        t_transmit();
        t_soft_reset();
        test_done();
    end
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        test_done();
    end
endmodule
`default_nettype wire
